/* File: cpm_chk_assertions.sv */
// port checks for the pin mode selector
`timescale 1ns/1ps
`default_nettype none
module cpm_chk #(
  parameter int unsigned WAKE_CYCLES = 8
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cfg_reset_pin_i,
  input wire logic cfg_serial_clock_i,
  input wire logic cfg_serial_data_or_standby_i,
  input wire logic cfg_serial_enable_i,
  input wire logic output_enable_i,
  input wire logic port_clock_o,
  input wire logic port_data_o,
  input wire logic port_enable_o,
  input wire logic regs_hold_default_o,
  input wire logic standby_o,
  input wire logic data_valid_o,
  input wire logic output_buffer_en_o,
  input wire logic readout_reg_o
);
  wire logic h = cfg_reset_pin_i, d = cfg_serial_data_or_standby_i, s = cfg_serial_clock_i;
  logic [31:0] wait_cnt;
  // counts cycles spent neither in standby nor with valid data
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      wait_cnt <= 32'h0;
    else if (data_valid_o || standby_o)
      wait_cnt <= 32'h0;
    else
      wait_cnt <= wait_cnt + 32'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_clk_role: assert property (port_clock_o == (s & ~h)) else $error("clock");
  a_data_role: assert property (port_data_o == (d & ~h)) else $error("data");
  a_en_role: assert property (port_enable_o == (h | cfg_serial_enable_i)) else $error("en");
  a_regs_default: assert property (regs_hold_default_o == h) else $error("regs");
  a_buf_follow: assert property (output_enable_i [*2] |-> output_buffer_en_o) else $error("oe");
  a_readout_off: assert property (h |=> !readout_reg_o) else $error("readout");
  a_standby_entry: assert property (h && d |=> standby_o) else $error("standby");
  a_wake_bound: assert property (wait_cnt <= WAKE_CYCLES) else $error("wake");
  a_standby_gate: assert property (!h |=> !standby_o) else $error("standby gate");
endmodule : cpm_chk
`default_nettype wire
bind cpm_pin_mode cpm_chk #(.WAKE_CYCLES(WAKE_CYCLES)) chk (.*);

/* File: cpm_host.sv */
// host model driving the configuration pins
`timescale 1ns/1ps
`default_nettype none
module cpm_host (input wire logic ser_i, sby_i, bit_i, tck_i,
  output logic rp_o, sc_o, sd_o, se_o);
  assign rp_o = ~ser_i; // registers start from defaults
  assign sc_o = ser_i & tck_i; // grounded outside serial use
  assign sd_o = ser_i ? bit_i : sby_i;
  assign se_o = ~ser_i; // held high outside serial use
endmodule : cpm_host
`default_nettype wire

/* File: cpm_map.svh */
// constants for the configuration pin mode selector
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH
`define CPM_CLK_PERIOD_PS   32'h1388
`define CPM_WAKE_MAX_US     32'h19
`define CPM_WAKE_TYP_US     32'h5
`define CPM_PS_PER_US       32'hf4240
`define CPM_WAKE_MAX_CYC    ((`CPM_WAKE_MAX_US * `CPM_PS_PER_US) / `CPM_CLK_PERIOD_PS)
`define CPM_WAKE_TYP_CYC    ((`CPM_WAKE_TYP_US * `CPM_PS_PER_US) / `CPM_CLK_PERIOD_PS)
`define CPM_READOUT_RST     1'h0
`define CPM_SHARED_PIN_RST  1'h0
`define CPM_BUFFER_EN_RST   1'h0
`endif

/* File: cpm_pin_mode.sv */
// pin role selection for the converter's configuration pins
// Operation
// - reset pin held high keeps every internal register at default values; here only readout_reg_o is held, the standby state machine still runs.
// - reset low makes the serial clock pin the programming port clock.
// - reset low makes the data pin the programming port data input.
// - reset high makes the data pin a standby control input.
// - reset low makes the enable pin frame programming port transfers.
// - output buffers enabled while output enable pin high, disabled when low.
// - shared pin shows overflow, or serial read data when readout bit set.
// - valid data at most 25 us after leaving standby.
`timescale 1ns/1ps
`default_nettype none
`include "cpm_map.svh"

module cpm_pin_mode
  import cpm_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = `CPM_WAKE_MAX_CYC
)(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic cfg_reset_pin_i,
  input  wire logic cfg_serial_clock_i,
  input  wire logic cfg_serial_data_or_standby_i,
  input  wire logic cfg_serial_enable_i,
  input  wire logic output_enable_i,
  input  wire logic readout_bit_i,
  input  wire logic overflow_i,
  input  wire logic serial_read_data_i,
  input  wire logic data_valid_i,
  output logic      port_clock_o,
  output logic      port_data_o,
  output logic      port_enable_o,
  output logic      port_active_o,
  output logic      regs_hold_default_o,
  output logic      standby_o,
  output logic      data_valid_o,
  output logic      output_buffer_en_o,
  output logic      overflow_or_readout_pin_o,
  output logic      readout_reg_o
);

  localparam int unsigned   CW        = $clog2(WAKE_CYCLES + 1);
  localparam logic [CW-1:0] WAKE_LAST = CW'(WAKE_CYCLES - 1);
  localparam logic [CW-1:0] WAKE_STEP = CW'(1);

  cpm_power_t    power_reg;
  logic [CW-1:0] wake_cnt_reg;
  logic          serial_mode;
  logic          standby_req;
  logic          wake_done;
  logic          shared_pin_src;

  // the reset pin level is used unregistered so roles follow it without delay
  assign serial_mode = ~cfg_reset_pin_i;

  // gating keeps a floating line in the other mode from clocking the port
  cpm_pin_gate #(
    .IDLE (1'h0)
  ) u_clock_gate (
    .sel_i (serial_mode),
    .pin_i (cfg_serial_clock_i),
    .pin_o (port_clock_o)
  );

  cpm_pin_gate #(
    .IDLE (1'h0)
  ) u_data_gate (
    .sel_i (serial_mode),
    .pin_i (cfg_serial_data_or_standby_i),
    .pin_o (port_data_o)
  );

  // enable idles high, which the port reads as no transfer framed
  cpm_pin_gate #(
    .IDLE (1'h1)
  ) u_enable_gate (
    .sel_i (serial_mode),
    .pin_i (cfg_serial_enable_i),
    .pin_o (port_enable_o)
  );

  assign port_active_o       = serial_mode & ~cfg_serial_enable_i;
  assign regs_hold_default_o = cfg_reset_pin_i;

  // readout select; held at its default while reset pin is high
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      readout_reg_o <= `CPM_READOUT_RST;
    end
    else if (cfg_reset_pin_i)
    begin
      readout_reg_o <= `CPM_READOUT_RST;
    end
    else
    begin
      readout_reg_o <= readout_bit_i;
    end
  end

  // the pin switches one cycle after the select, never mid-cycle
  always_comb
  begin
    if (readout_reg_o)
    begin
      shared_pin_src = serial_read_data_i;
    end
    else
    begin
      shared_pin_src = overflow_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      overflow_or_readout_pin_o <= `CPM_SHARED_PIN_RST;
    end
    else
    begin
      overflow_or_readout_pin_o <= shared_pin_src;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      output_buffer_en_o <= `CPM_BUFFER_EN_RST;
    end
    else
    begin
      output_buffer_en_o <= output_enable_i;
    end
  end

  // standby is only meaningful while the data pin is a control input
  assign standby_req = cfg_reset_pin_i & cfg_serial_data_or_standby_i;

  // the counter gives the worst case; a ready core may end the wait early
  assign wake_done = data_valid_i | (wake_cnt_reg == WAKE_LAST);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      power_reg <= CPM_ST_ACTIVE;
    end
    else
    begin
      case (power_reg)
        CPM_ST_ACTIVE:
        begin
          if (standby_req)
          begin
            power_reg <= CPM_ST_STANDBY;
          end
        end
        CPM_ST_STANDBY:
        begin
          if (!standby_req)
          begin
            power_reg <= CPM_ST_WAKING;
          end
        end
        CPM_ST_WAKING:
        begin
          if (standby_req)
          begin
            power_reg <= CPM_ST_STANDBY;
          end
          else if (wake_done)
          begin
            power_reg <= CPM_ST_ACTIVE;
          end
        end
        default:
        begin
          power_reg <= CPM_ST_ACTIVE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wake_cnt_reg <= '0;
    end
    else if (power_reg == CPM_ST_WAKING)
    begin
      wake_cnt_reg <= wake_cnt_reg + WAKE_STEP;
    end
    else
    begin
      wake_cnt_reg <= '0;
    end
  end

  assign standby_o    = (power_reg == CPM_ST_STANDBY);
  assign data_valid_o = (power_reg == CPM_ST_ACTIVE);

endmodule : cpm_pin_mode

// passes a pin through in its own mode and parks it at a safe level otherwise
module cpm_pin_gate
#(
  parameter logic IDLE = 1'h0
)(
  input  wire logic sel_i,
  input  wire logic pin_i,
  output logic      pin_o
);

  always_comb
  begin
    if (sel_i)
    begin
      pin_o = pin_i;
    end
    else
    begin
      pin_o = IDLE;
    end
  end

endmodule : cpm_pin_gate
`default_nettype wire

/* File: cpm_pkg.sv */
// types for the configuration pin mode selector
package cpm_pkg;
  typedef enum logic [2:0] {
    CPM_ST_ACTIVE  = 3'h1,
    CPM_ST_STANDBY = 3'h2,
    CPM_ST_WAKING  = 3'h4
  } cpm_power_t;
endpackage : cpm_pkg

/* File: tb.sv */
// self-checking bench for the pin mode selector
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0, rst_i = 1'b1, ser = 1'b0, sby = 1'b0, bt = 1'b0, output_enable_i = 1'b0;
  logic readout_bit_i = 1'b0, overflow_i = 1'b0, serial_read_data_i = 1'b0, data_valid_i = 1'b0;
  logic cfg_reset_pin_i, cfg_serial_clock_i, cfg_serial_data_or_standby_i, cfg_serial_enable_i;
  logic port_clock_o, port_data_o, port_enable_o, port_active_o, regs_hold_default_o, standby_o;
  logic data_valid_o, output_buffer_en_o, overflow_or_readout_pin_o, readout_reg_o;
  int errors = 0, checked = 0;
  always #2.5 clk_i = ~clk_i;
  cpm_host host (.ser_i(ser), .sby_i(sby), .bit_i(bt), .tck_i(~clk_i), .rp_o(cfg_reset_pin_i),
    .sc_o(cfg_serial_clock_i), .sd_o(cfg_serial_data_or_standby_i), .se_o(cfg_serial_enable_i));
  cpm_pin_mode #(.WAKE_CYCLES(8)) dut (.*);
  task chk(input logic g, input logic e);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %0t bad level", $time);
    end
  endtask : chk
  task t_serial;
    ser = 1'b1; bt = 1'b1; @(negedge clk_i); #1;
    chk(port_data_o, 1'b1);
    chk(port_clock_o, 1'b1);
    chk(port_enable_o, 1'b0);
    chk(port_active_o, 1'b1);
    chk(regs_hold_default_o, 1'b0);
    @(negedge clk_i); ser = 1'b0; #1;
    chk(port_data_o, 1'b0);
    chk(port_enable_o, 1'b1);
    $display("serial roles done");
  endtask : t_serial
  task t_standby;
    @(negedge clk_i); sby = 1'b1; output_enable_i = 1'b1; repeat (2) @(negedge clk_i);
    chk(standby_o, 1'b1);
    chk(data_valid_o, 1'b0);
    chk(output_buffer_en_o, 1'b1);
    sby = 1'b0; output_enable_i = 1'b0; repeat (5) @(negedge clk_i);
    chk(data_valid_o, 1'b0);
    repeat (6) @(negedge clk_i);
    chk(data_valid_o, 1'b1);
    chk(output_buffer_en_o, 1'b0);
    sby = 1'b1; repeat (2) @(negedge clk_i);
    sby = 1'b0; data_valid_i = 1'b1; repeat (2) @(negedge clk_i);
    chk(data_valid_o, 1'b1);
    data_valid_i = 1'b0;
    $display("standby done");
  endtask : t_standby
  task t_readout;
    @(negedge clk_i);
    ser = 1'b1; readout_bit_i = 1'b1; serial_read_data_i = 1'b1; repeat (2) @(negedge clk_i);
    chk(readout_reg_o, 1'b1);
    chk(overflow_or_readout_pin_o, 1'b1);
    readout_bit_i = 1'b0; serial_read_data_i = 1'b0; overflow_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk(readout_reg_o, 1'b0);
    chk(overflow_or_readout_pin_o, 1'b1);
    readout_bit_i = 1'b1; overflow_i = 1'b0; ser = 1'b0; @(negedge clk_i);
    chk(readout_reg_o, 1'b0);
    readout_bit_i = 1'b0;
    $display("readout done");
  endtask : t_readout
  task test_done;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    t_serial;
    t_readout;
    t_standby;
    test_done;
  end
  initial
  begin
    #2000;
    errors++;
    test_done;
  end
endmodule : tb
`default_nettype wire
